// file: rtl/esa_alu.sv
// Extremum select ALU: max/min with difference, dual-lane min, minimum compare.
// Assumes operands arrive with op_valid for one cycle; results are registered.
`timescale 1ns/100ps
`default_nettype none
`include "esa_regs.svh"

module esa_alu (
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire logic                   op_valid,
    input  wire esa_pkg::esa_op_t       op_sel,
    input  wire logic [`ESA_OPC_W-1:0]  opcode,
    input  wire logic [`ESA_ACC_W-1:0]  first_source_acc,
    input  wire logic [`ESA_ACC_W-1:0]  second_source_acc,
    input  wire esa_pkg::esa_kind_t     cmp_src_kind,
    input  wire esa_pkg::esa_kind_t     cmp_dst_kind,
    input  wire logic [`ESA_ACC_W-1:0]  cmp_src_acc,
    input  wire logic [`ESA_ACC_W-1:0]  cmp_dst_acc,
    input  wire logic [15:0]            addr_or_temp_reg_src,
    input  wire logic [15:0]            addr_or_temp_reg_dst,
    input  wire logic [`ESA_ACC_W-1:0]  accumulator_one,
    input  wire logic                   wide_arith_mode,
    input  wire logic                   data_saturation_mode,
    input  wire logic                   sign_extension_mode,
    input  wire logic                   legacy_compat_mode,
    output logic [`ESA_ACC_W-1:0]       extremum_dest_acc,
    output logic [`ESA_ACC_W-1:0]       difference_dest_acc,
    output logic                        acc_result_valid,
    output logic                        diff_result_valid,
    output logic [15:0]                 ta_result,
    output logic                        ta_result_valid,
    output logic [`ESA_TRN_W-1:0]       transition_reg_zero,
    output logic [`ESA_TRN_W-1:0]       transition_reg_one,
    output logic                        carry_flag,
    output logic                        dest_overflow_flag,
    output logic                        test_condition_flag
);
    import esa_pkg::*;

    // ------------------------------------------------------------
    // Single-lane subtraction
    // ------------------------------------------------------------
    logic                  eff_wide;
    logic [`ESA_ACC_W:0]   sub_full;
    logic [`ESA_ACC_W-1:0] sub_res;
    logic                  sub_ovf;
    logic                  sub_carry;
    logic [`ESA_ACC_W-1:0] sub_sat;
    logic                  src_lt;

    // Legacy mode forces wide behaviour on every single-lane op
    // The minimum compare reuses it too, so one signal serves both
    assign eff_wide = wide_arith_mode | legacy_compat_mode;
    // second minus first
    // Zero-extended by one bit so the top bit is the wide borrow
    assign sub_full = {1'b0, second_source_acc} - {1'b0, first_source_acc};
    assign sub_res  = sub_full[`ESA_ACC_W-1:0];

    // mode-dependent overflow and carry
    // Carry is the inverse of borrow: 1 when no borrow leaves the top
    always_comb begin
        if (eff_wide) begin
            sub_ovf   = (second_source_acc[39] != first_source_acc[39])
                        && (sub_res[39] != second_source_acc[39]);
            sub_carry = ~sub_full[`ESA_ACC_W];
        end else begin
            sub_ovf   = (second_source_acc[31] != first_source_acc[31])
                        && (sub_res[31] != second_source_acc[31]);
            // Carry into bit 32 recovered from the sum bit and both operands;
            // the guard bits still take part in the subtraction itself
            sub_carry = sub_res[32] ^ second_source_acc[32] ^ ~first_source_acc[32];
        end
    end

    // saturation on overflow
    // Clamp direction follows the minuend sign at the overflow bit
    always_comb begin
        sub_sat = sub_res;
        if (sub_ovf && data_saturation_mode) begin
            if (eff_wide)
                sub_sat = second_source_acc[39] ? `ESA_WIDE_SAT_NEG : `ESA_WIDE_SAT_POS;
            else
                sub_sat = second_source_acc[31] ? `ESA_ACC_SAT_NEG : `ESA_ACC_SAT_POS;
        end
    end

    // compare width follows wide mode
    // Signed compare; a tie keeps the first source for the maximum
    assign src_lt = eff_wide
        ? ($signed(first_source_acc) < $signed(second_source_acc))
        : ($signed(first_source_acc[31:0]) < $signed(second_source_acc[31:0]));

    // ------------------------------------------------------------
    // Dual-lane subtraction
    // ------------------------------------------------------------
    logic [23:0] hi_x;
    logic [23:0] hi_y;
    logic [15:0] lo_x;
    logic [15:0] lo_y;
    logic [24:0] hi_full;
    logic [15:0] lo_diff;
    logic [23:0] hi_diff;
    logic        hi_ovf;
    logic        lo_ovf;
    logic        hi_lt;
    logic        lo_lt;
    logic [23:0] hi_out;
    logic [15:0] lo_out;
    logic        dual_sat;

    // lane split
    // Guard bits ride with the high lane; the low lane wraps in 16 bits
    // and its carry is never reported
    assign hi_x    = first_source_acc[39:16];
    assign hi_y    = second_source_acc[39:16];
    assign lo_x    = first_source_acc[15:0];
    assign lo_y    = second_source_acc[15:0];
    assign hi_full = {1'b0, hi_y} - {1'b0, hi_x};
    assign hi_diff = hi_full[23:0];
    assign lo_diff = lo_y - lo_x;
    assign hi_ovf  = (hi_y[15] != hi_x[15]) && (hi_diff[15] != hi_y[15]);
    assign lo_ovf  = (lo_y[15] != lo_x[15]) && (lo_diff[15] != lo_y[15]);
    // lane signs at bit 31 and bit 15
    assign hi_lt   = $signed(hi_x[15:0]) < $signed(hi_y[15:0]);
    assign lo_lt   = $signed(lo_x) < $signed(lo_y);
    // legacy mode drops saturation
    // Legacy mode keeps the high-lane overflow but never clamps
    assign dual_sat = data_saturation_mode & ~legacy_compat_mode;

    // independent lane clamping
    // Clamp codes follow the minuend sign at each lane's overflow bit
    always_comb begin
        hi_out = hi_diff;
        lo_out = lo_diff;
        if (dual_sat && hi_ovf)
            hi_out = hi_y[15] ? `ESA_HI_SAT_NEG : `ESA_HI_SAT_POS;
        if (dual_sat && lo_ovf)
            lo_out = lo_y[15] ? `ESA_LO_SAT_NEG : `ESA_LO_SAT_POS;
    end

    // ------------------------------------------------------------
    // Minimum compare
    // ------------------------------------------------------------
    logic [`ESA_ACC_W-1:0] ext_src;
    logic [`ESA_ACC_W-1:0] cmp_ref;
    logic [15:0]           ta_src;
    logic                  cmp_lt;
    logic                  ta_lt;
    logic                  mixed;
    logic [15:0]           ta_dst;

    // sign extension of address register source
    // With extension off the upper bits are zero filled
    assign ext_src = (cmp_src_kind == ESA_KIND_TA)
        ? {{24{sign_extension_mode & addr_or_temp_reg_src[15]}}, addr_or_temp_reg_src}
        : cmp_src_acc;
    // legacy compares against accumulator one
    // Register-destination compares never use accumulator one
    assign cmp_ref = legacy_compat_mode ? accumulator_one : cmp_dst_acc;
    assign cmp_lt = eff_wide
        ? ($signed(ext_src) < $signed(cmp_ref))
        : ($signed(ext_src[31:0]) < $signed(cmp_ref[31:0]));
    assign ta_src = (cmp_src_kind == ESA_KIND_TA) ? addr_or_temp_reg_src : cmp_src_acc[15:0];
    // accumulator low half stands in for an accumulator destination
    assign ta_dst = (cmp_dst_kind == ESA_KIND_TA) ? addr_or_temp_reg_dst : cmp_dst_acc[15:0];
    assign ta_lt  = $signed(ta_src) < $signed(ta_dst);
    assign mixed  = cmp_src_kind != cmp_dst_kind;

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    // Accumulator results; held between operations
    // A no-op or a register-destination compare leaves them untouched
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            extremum_dest_acc   <= '0;
            difference_dest_acc <= '0;
            acc_result_valid    <= 1'b0;
            diff_result_valid   <= 1'b0;
        end else begin
            acc_result_valid  <= 1'b0;
            diff_result_valid <= 1'b0;
            if (op_valid) begin
                case (op_sel)
                    ESA_OP_MAX_DIFF: begin
                        extremum_dest_acc   <= src_lt ? second_source_acc : first_source_acc;
                        difference_dest_acc <= sub_sat;
                        acc_result_valid    <= 1'b1;
                        diff_result_valid   <= 1'b1;
                    end
                    ESA_OP_MIN_DIFF: begin
                        extremum_dest_acc   <= src_lt ? first_source_acc : second_source_acc;
                        difference_dest_acc <= sub_sat;
                        acc_result_valid    <= 1'b1;
                        diff_result_valid   <= 1'b1;
                    end
                    ESA_OP_DUAL_MIN_DIFF: begin
                        extremum_dest_acc   <= {hi_lt ? hi_x : hi_y, lo_lt ? lo_x : lo_y};
                        difference_dest_acc <= {hi_out, lo_out};
                        acc_result_valid    <= 1'b1;
                        diff_result_valid   <= 1'b1;
                    end
                    ESA_OP_MIN_CMP: begin
                        // plain copy, never saturated
                        // Register destinations live in the address-unit block
                        if (cmp_dst_kind == ESA_KIND_ACC) begin
                            extremum_dest_acc <= cmp_lt ? ext_src : cmp_ref;
                            acc_result_valid  <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Address-unit destination of the minimum compare
    // The pulse marks the one cycle in which ta_result is fresh
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ta_result       <= 16'h0000;
            ta_result_valid <= 1'b0;
        end else begin
            ta_result_valid <= 1'b0;
            if (op_valid && op_sel == ESA_OP_MIN_CMP && cmp_dst_kind == ESA_KIND_TA) begin
                ta_result       <= ta_lt ? ta_src : addr_or_temp_reg_dst;
                ta_result_valid <= 1'b1;
            end
        end
    end

    // Transition registers
    // Max and min move only the named register, so the other keeps its history; the dual op shifts both
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            transition_reg_zero <= 16'h0000;
            transition_reg_one  <= 16'h0000;
        end else if (op_valid) begin
            case (op_sel)
                ESA_OP_MAX_DIFF, ESA_OP_MIN_DIFF: begin
                    if (opcode[`ESA_OPC_TRN_BIT])
                        transition_reg_one  <= {~((op_sel == ESA_OP_MAX_DIFF) ? ~src_lt
                                                  : src_lt), transition_reg_one[15:1]};
                    else
                        transition_reg_zero <= {~((op_sel == ESA_OP_MAX_DIFF) ? ~src_lt
                                                  : src_lt), transition_reg_zero[15:1]};
                end
                ESA_OP_DUAL_MIN_DIFF: begin
                    transition_reg_zero <= {~hi_lt, transition_reg_zero[15:1]};
                    transition_reg_one  <= {~lo_lt, transition_reg_one[15:1]};
                end
                default: begin
                end
            endcase
        end
    end

    // Status flags
    // Each op writes only the flags it owns; the rest hold
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            carry_flag          <= 1'b0;
            dest_overflow_flag  <= 1'b0;
            test_condition_flag <= 1'b0;
        end else if (op_valid) begin
            case (op_sel)
                ESA_OP_MAX_DIFF, ESA_OP_MIN_DIFF: begin
                    carry_flag         <= sub_carry;
                    dest_overflow_flag <= sub_ovf;
                end
                ESA_OP_DUAL_MIN_DIFF: begin
                    // carry at bit 31
                    // Carry into bit 32 of the high lane, guard bits aside
                    carry_flag <= hi_full[16] ^ hi_y[16] ^ ~hi_x[16];
                    dest_overflow_flag <= hi_ovf | (lo_ovf & ~legacy_compat_mode);
                end
                ESA_OP_MIN_CMP: begin
                    if (cmp_dst_kind == ESA_KIND_ACC)
                        carry_flag <= ~cmp_lt;
                    if (mixed)
                        test_condition_flag <= ta_lt;
                end
                default: begin
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// file: rtl/esa_pkg.sv
// Types shared by the extremum select ALU and its bench.
// Assumes the decoder upstream has already classified the instruction.
package esa_pkg;
    // Operation selected by the decoder for this cycle
    typedef enum logic [2:0] {
        ESA_OP_NONE,
        ESA_OP_MAX_DIFF,
        ESA_OP_MIN_DIFF,
        ESA_OP_DUAL_MIN_DIFF,
        ESA_OP_MIN_CMP
    } esa_op_t;
    // Register class of an operand of the minimum compare
    typedef enum logic {
        ESA_KIND_ACC,
        ESA_KIND_TA
    } esa_kind_t;
endpackage

// file: rtl/esa_regs.svh
// Constants for the extremum select ALU: widths, opcode fields, saturation values.
// Assumes the includer is the extremum select ALU or its bench.
//
// How it works
// - Max-difference op is 3 bytes, one cycle; last opcode bit picks transition reg.
// - Max-difference writes second source minus first source into difference accumulator.
// - Overflow and carry follow wide mode; carry is the complement of borrow.
// - Overflowing max-difference result saturates when data saturation mode is on.
// - Larger source goes to extremum destination; carry comes only from the subtraction.
// - Chosen transition reg shifts right; top bit 0 if first source chosen.
// - Accumulator versus address register compares low 16 bits; test flag shows result.
// - Address register source is sign-extended to 40 bits per sign extension mode.
// - Narrow mode compares bits 31-0; smaller source copied whole, carry cleared, else set.
// - Wide mode compares bits 39-0 with the same update and carry behaviour.
// - Accumulator-destination minimum compare has no overflow and no saturation.
// - Address register destination compares low 16 bits, copies smaller source, no overflow.
// - Legacy mode acts wide; accumulator destination compares against accumulator one.
// - Minimum-difference has dual 16-bit and single 40-bit forms, both in data ALU.
// - Dual mode lanes are bits 39-16 and 15-0; each writes second minus first.
// - Dual overflow at bit 15 low and bit 31 high sets destination overflow flag.
// - Dual mode carry is the high lane carry taken at bit 31.
// - With saturation each overflowing lane clamps on its own to its lane limits.
// - Dual mode picks each lane's smaller part; signs at bit 15 and bit 31.
// - Dual mode shifts both transition regs; zero tracks high lane, one low lane.
// - Legacy mode dual op ignores saturation; overflow only from high lane.
`ifndef ESA_REGS_SVH
`define ESA_REGS_SVH
`define ESA_ACC_W        40
`define ESA_TRN_W        16
`define ESA_OPC_W        24
`define ESA_OPC_TRN_BIT  0
`define ESA_LO_SAT_POS   16'h7FFF
`define ESA_LO_SAT_NEG   16'h8000
`define ESA_HI_SAT_POS   24'h007FFF
`define ESA_HI_SAT_NEG   24'hFF8000
`define ESA_ACC_SAT_POS  40'h007FFFFFFF
`define ESA_ACC_SAT_NEG  40'hFF80000000
`define ESA_WIDE_SAT_POS 40'h7FFFFFFFFF
`define ESA_WIDE_SAT_NEG 40'h8000000000
`endif

// file: test/esa_alu_props.sv
// Checker for the extremum select ALU: port relations over time.
// Assumes it is bound to esa_alu and sees its ports by name.
`timescale 1ns/100ps
`default_nettype none
`include "esa_regs.svh"

module esa_alu_props (
    input wire logic                  sys_clk,
    input wire logic                  reset,
    input wire logic                  op_valid,
    input wire esa_pkg::esa_op_t      op_sel,
    input wire logic [`ESA_OPC_W-1:0] opcode,
    input wire logic [`ESA_ACC_W-1:0] first_source_acc,
    input wire logic [`ESA_ACC_W-1:0] second_source_acc,
    input wire esa_pkg::esa_kind_t    cmp_src_kind,
    input wire esa_pkg::esa_kind_t    cmp_dst_kind,
    input wire logic [`ESA_ACC_W-1:0] cmp_src_acc,
    input wire logic [`ESA_ACC_W-1:0] cmp_dst_acc,
    input wire logic                  wide_arith_mode,
    input wire logic                  data_saturation_mode,
    input wire logic                  legacy_compat_mode,
    input wire logic                  acc_result_valid,
    input wire logic                  diff_result_valid,
    input wire logic                  ta_result_valid,
    input wire logic [`ESA_ACC_W-1:0] extremum_dest_acc,
    input wire logic [`ESA_ACC_W-1:0] difference_dest_acc,
    input wire logic [`ESA_TRN_W-1:0] transition_reg_zero,
    input wire logic [`ESA_TRN_W-1:0] transition_reg_one,
    input wire logic                  carry_flag,
    input wire logic                  dest_overflow_flag
);
    import esa_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // Issue decode and reference arithmetic; wide also covers legacy mode
    wire logic              is_max = op_valid && op_sel == ESA_OP_MAX_DIFF;
    wire logic              is_dual = op_valid && op_sel == ESA_OP_DUAL_MIN_DIFF;
    wire logic              is_cmp = op_valid && op_sel == ESA_OP_MIN_CMP;
    wire logic              wide = wide_arith_mode || legacy_compat_mode;
    wire logic              x_lt_y = $signed(first_source_acc) < $signed(second_source_acc);
    wire logic              s_lt_d = $signed(cmp_src_acc) < $signed(cmp_dst_acc);
    wire logic [39:0]       full_diff = second_source_acc - first_source_acc;
    wire logic [15:0]       low_diff = second_source_acc[15:0] - first_source_acc[15:0];
    wire logic [15:0]       hi_a = second_source_acc[31:16];
    wire logic [15:0]       hi_b = first_source_acc[31:16];
    wire logic [15:0]       hi_d = hi_a - hi_b;
    wire logic              hi_ovf = (hi_a[15] != hi_b[15]) && (hi_d[15] != hi_a[15]);

    property p_issue_pulse;
        is_max |=> acc_result_valid && diff_result_valid;
    endproperty
    a_issue_pulse: assert property (p_issue_pulse) else $error("valid pulse missing");
    property p_max_pick;
        is_max && wide |=> extremum_dest_acc ==
            ($past(x_lt_y) ? $past(second_source_acc) : $past(first_source_acc));
    endproperty
    a_max_pick: assert property (p_max_pick) else $error("larger source not stored");
    property p_max_diff;
        is_max && !data_saturation_mode |=> difference_dest_acc == $past(full_diff);
    endproperty
    a_max_diff: assert property (p_max_diff) else $error("difference wrong");
    property p_max_trn;
        is_max && wide && !opcode[0] |=> $stable(transition_reg_one) &&
            transition_reg_zero == (($past(transition_reg_zero) >> 1) | {$past(x_lt_y), 15'h0000});
    endproperty
    a_max_trn: assert property (p_max_trn) else $error("decision shift wrong");
    property p_dual_shift;
        is_dual |=> (transition_reg_zero & 16'h7FFF) == ($past(transition_reg_zero) >> 1)
            && (transition_reg_one & 16'h7FFF) == ($past(transition_reg_one) >> 1);
    endproperty
    a_dual_shift: assert property (p_dual_shift) else $error("dual shift wrong");
    property p_dual_low;
        is_dual && !data_saturation_mode |=> difference_dest_acc[15:0] == $past(low_diff);
    endproperty
    a_dual_low: assert property (p_dual_low) else $error("low lane difference wrong");
    property p_dual_legacy;
        is_dual && legacy_compat_mode |=> dest_overflow_flag == $past(hi_ovf);
    endproperty
    a_dual_legacy: assert property (p_dual_legacy) else $error("legacy overflow wrong");
    property p_cmp_wide;
        is_cmp && cmp_src_kind == ESA_KIND_ACC && cmp_dst_kind == ESA_KIND_ACC && wide_arith_mode
            && !legacy_compat_mode |=> carry_flag == !$past(s_lt_d);
    endproperty
    a_cmp_wide: assert property (p_cmp_wide) else $error("compare carry wrong");
    property p_cmp_no_ovf;
        is_cmp |=> $stable(dest_overflow_flag);
    endproperty
    a_cmp_no_ovf: assert property (p_cmp_no_ovf) else $error("compare touched overflow");
    property p_ta_dst;
        is_cmp && cmp_dst_kind == ESA_KIND_TA |=> ta_result_valid;
    endproperty
    a_ta_dst: assert property (p_ta_dst) else $error("register result missing");
endmodule

bind esa_alu esa_alu_props esa_alu_props_i (.*);
`default_nettype wire

// file: test/test_extremum_select_alu.sv
// Bench for the extremum select ALU: directed operations, expected results.
// Assumes the design and checker compiled first, rtl/ on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "esa_regs.svh"

module test_extremum_select_alu;
    import esa_pkg::*;
    logic                  sys_clk = 0, reset = 1, op_valid = 0;
    logic                  wide_arith_mode = 0, data_saturation_mode = 0;
    logic                  sign_extension_mode = 0, legacy_compat_mode = 0;
    esa_op_t               op_sel = ESA_OP_NONE;
    esa_kind_t             cmp_src_kind = ESA_KIND_ACC, cmp_dst_kind = ESA_KIND_ACC;
    logic [`ESA_OPC_W-1:0] opcode = '0;
    logic [`ESA_ACC_W-1:0] first_source_acc = '0, second_source_acc = '0;
    logic [`ESA_ACC_W-1:0] cmp_src_acc = '0, cmp_dst_acc = '0, accumulator_one = '0;
    logic [15:0]           addr_or_temp_reg_src = '0, addr_or_temp_reg_dst = '0;
    logic [`ESA_ACC_W-1:0] extremum_dest_acc, difference_dest_acc;
    logic [15:0]           ta_result, transition_reg_zero, transition_reg_one;
    logic                  acc_result_valid, diff_result_valid, ta_result_valid;
    logic                  carry_flag, dest_overflow_flag, test_condition_flag;
    logic [15:0]           e0 = '0, e1 = '0;
    int                    fails = 0, compares = 0;

    esa_alu esa_alu_i (.*);

    // Free-running 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    // Any result kind, widened to an accumulator
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Issue one op; valid stays up so back-to-back issue is exercised
    task automatic run(input esa_op_t op, input logic [39:0] x, input logic [39:0] y);
        first_source_acc = x;
        second_source_acc = y;
        cmp_src_acc = x;
        cmp_dst_acc = y;
        op_sel = op;
        op_valid = 1;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard, far beyond the few dozen cycles of the sequence
    initial begin
        #100000;
        fails++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        reset = 0;
        chk(extremum_dest_acc, '0);
        chk({carry_flag, dest_overflow_flag, transition_reg_zero}, '0);
        // Single-lane maximum, plain and with wide overflow
        wide_arith_mode = 1;
        run(ESA_OP_MAX_DIFF, 40'h0000000005, 40'h0000000009);
        e0 = {1'b1, e0[15:1]};
        chk(extremum_dest_acc, 40'h0000000009);
        chk(difference_dest_acc, 40'h0000000004);
        chk(carry_flag, 1'b1);
        chk(transition_reg_zero, e0);
        chk(diff_result_valid, 1'b1);
        opcode = 24'h000001;
        run(ESA_OP_MAX_DIFF, 40'h0000000001, 40'h8000000000);
        e1 = {1'b0, e1[15:1]};
        chk(extremum_dest_acc, 40'h0000000001);
        chk(difference_dest_acc, 40'h7FFFFFFFFF);
        chk(dest_overflow_flag, 1'b1);
        chk({transition_reg_zero, transition_reg_one}, {e0, e1});
        // Narrow compare and saturation at bit 31
        wide_arith_mode = 0;
        data_saturation_mode = 1;
        opcode = 24'h000000;
        run(ESA_OP_MAX_DIFF, 40'hFFFFFFFFFF, 40'h007FFFFFFF);
        e0 = {1'b1, e0[15:1]};
        chk(difference_dest_acc, `ESA_ACC_SAT_POS);
        chk(extremum_dest_acc, 40'h007FFFFFFF);
        chk(carry_flag, 1'b0);
        // Legacy mode widens the single-lane compare
        legacy_compat_mode = 1;
        data_saturation_mode = 0;
        opcode = 24'h000001;
        run(ESA_OP_MAX_DIFF, 40'h0080000000, 40'h0000000000);
        e1 = {1'b0, e1[15:1]};
        chk(extremum_dest_acc, 40'h0080000000);
        chk(transition_reg_one, e1);
        // Single-lane minimum, widened by legacy mode
        run(ESA_OP_MIN_DIFF, 40'h0000000000, 40'h0080000000);
        e1 = {1'b0, e1[15:1]};
        chk({extremum_dest_acc, carry_flag}, {40'h0000000000, 1'b1});
        chk(difference_dest_acc, 40'h0080000000);
        chk(transition_reg_one, e1);
        // Dual minimum with high-lane overflow, saturating then legacy
        legacy_compat_mode = 0;
        data_saturation_mode = 1;
        run(ESA_OP_DUAL_MIN_DIFF, 40'h1024002222, 40'h008000DDDE);
        e0 = {1'b1, e0[15:1]};
        e1 = {1'b1, e1[15:1]};
        chk(difference_dest_acc, 40'hFF8000BBBC);
        chk(extremum_dest_acc, 40'h008000DDDE);
        chk({dest_overflow_flag, carry_flag}, 2'h3);
        chk({transition_reg_zero, transition_reg_one}, {e0, e1});
        legacy_compat_mode = 1;
        data_saturation_mode = 0;
        run(ESA_OP_DUAL_MIN_DIFF, 40'h1024002222, 40'h008000DDDE);
        chk(difference_dest_acc, 40'hF05C00BBBC);
        chk(dest_overflow_flag, 1'b1);
        // Low-lane-only overflow: clamps alone, unseen in legacy mode
        data_saturation_mode = 1;
        for (int i = 0; i < 2; i++) begin
            legacy_compat_mode = !i[0];
            run(ESA_OP_DUAL_MIN_DIFF, 40'h0000000001, 40'h0000008000);
            chk(difference_dest_acc, i ? 40'h0000008000 : 40'h0000007FFF);
            chk(dest_overflow_flag, i[0]);
            chk(extremum_dest_acc, 40'h0000008000);
        end
        // Accumulator minimum compare, narrow then wide
        legacy_compat_mode = 0;
        run(ESA_OP_MIN_CMP, 40'h0100000000, 40'h0000000005);
        chk({extremum_dest_acc, carry_flag}, {40'h0100000000, 1'b0});
        chk(transition_reg_zero, {3'h7, e0[15:3]});
        wide_arith_mode = 1;
        run(ESA_OP_MIN_CMP, 40'h0100000000, 40'h0000000005);
        chk({extremum_dest_acc, carry_flag}, {40'h0000000005, 1'b1});
        // Legacy compare against accumulator one
        wide_arith_mode = 0;
        legacy_compat_mode = 1;
        accumulator_one = 40'h0000000002;
        run(ESA_OP_MIN_CMP, 40'h0000000003, 40'h0000000077);
        chk({extremum_dest_acc, carry_flag}, {40'h0000000002, 1'b1});
        // Register source, both extension modes, then the test flag
        legacy_compat_mode = 0;
        cmp_src_kind = ESA_KIND_TA;
        addr_or_temp_reg_src = 16'h8000;
        for (int i = 0; i < 2; i++) begin
            sign_extension_mode = !i[0];
            run(ESA_OP_MIN_CMP, 40'h0000000000, 40'h0000000000);
            chk(extremum_dest_acc, i ? 40'h0000000000 : 40'hFFFFFF8000);
            chk(carry_flag, i[0]);
        end
        addr_or_temp_reg_src = 16'h0003;
        run(ESA_OP_MIN_CMP, 40'h0000000000, 40'h0000000005);
        chk(test_condition_flag, 1'b1);
        // Register destination keeps the smaller low half
        cmp_src_kind = ESA_KIND_ACC;
        cmp_dst_kind = ESA_KIND_TA;
        addr_or_temp_reg_dst = 16'h0007;
        run(ESA_OP_MIN_CMP, 40'h0000000002, 40'h0000000000);
        chk({ta_result_valid, ta_result}, {1'b1, 16'h0002});
        // No-op issue leaves every result pulse low
        run(ESA_OP_NONE, 40'h0000000000, 40'h0000000000);
        chk({acc_result_valid, diff_result_valid, ta_result_valid}, 3'h0);
        complete_run();
    end
endmodule
`default_nettype wire
